// ### rtl/aei_top.sv
`timescale 1ns/1ps
// Contract
// RULE1 - Instruction fetch from an odd address is an address error.
// RULE2 - Instruction fetch from peripheral register space is an address error.
// RULE3 - Fetch from external space in single-chip configuration is an address error.
// RULE4 - 16-bit data access at an odd address is an address error.
// RULE5 - 32-bit data access not on a 32-bit boundary is an address error.
// RULE6 - Peripheral space: 32-bit access to an 8-bit region errs, others allowed.
// RULE7 - Data access to external space in single-chip configuration errs.
// RULE8 - End the faulty bus cycle, finish the instruction, then enter the exception.
// RULE9 - Address-error entry pushes status word, then the next instruction address.
// RULE10 - Then fetch the address-error vector and jump, with no delay slot.
// RULE11 - Sources: NMI, user break, eight external lines, 4 engine and 24 timer requests.
// RULE12 - Every interrupt source has its own vector number and table offset.
// RULE13 - Priority scale runs from 0 lowest to 16 highest.
// RULE14 - NMI is level 16 and is accepted whatever the mask.
// RULE15 - User break has fixed level 15.
// RULE16 - External and peripheral levels are programmable 0 to 15, never 16.
// RULE17 - Among simultaneous requests the highest priority one is processed.
// RULE18 - Maskable interrupt accepted only when its level exceeds the mask field.
// RULE19 - Interrupt entry pushes status word and program counter.
// RULE20 - Accepted level goes to the mask field; NMI loads 1111.
// RULE21 - Then fetch the interrupt vector and start executing there.
// RULE22 - Vector slot address is vector base plus four times the vector number.
// RULE23 - Pushed counter for interrupts is the next instruction's address.
// RULE24 - Whole entry completes first; no maskable request accepted meanwhile.
module aei_top
  import aei_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic ACC_VALID,
  input wire logic ACC_FETCH,
  input wire logic [1:0] ACC_SIZE,
  input wire logic [1:0] ACC_MASTER,
  input wire logic [31:0] ACC_ADDR,
  input wire logic ACC_PERIPH,
  input wire logic ACC_PERIPH8,
  input wire logic ACC_EXTERNAL,
  output logic ADDR_ERR,
  input wire logic NMI_PIN,
  input wire logic [AEI_NIRQ-1:0] IRQ_N,
  input wire logic UBRK_REQ,
  input wire logic [AEI_NDMA-1:0] DMA_REQ,
  input wire logic [AEI_NTMR-1:0] TMR_REQ,
  input wire logic INSN_DONE,
  input wire logic [31:0] STATUS_WORD,
  input wire logic [31:0] NEXT_PC,
  input wire logic [31:0] SP_IN,
  output logic EXC_BUSY,
  output logic EXC_JUMP,
  output logic [31:0] EXC_TARGET,
  output logic [31:0] EXC_SR,
  output logic [31:0] EXC_SP,
  output logic INT_ACK,
  output logic [7:0] INT_ACK_VEC,
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic [31:0] MEM_ADDR,
  output logic [31:0] MEM_WDATA,
  input wire logic MEM_ACK,
  input wire logic [31:0] MEM_RDATA
);

  function automatic logic [2:0] prio_index(input logic [11:0] addr);
    logic [11:0] rel;
    rel = addr - AEI_OFF_PRIO0;
    prio_index = rel[4:2];
  endfunction

  // Level of one source, widened to the 0..16 scale
  function automatic logic [4:0] src_level(input logic [143:0] prio, input int idx);
    src_level = {1'b0, prio[idx*4 +: 4]};
  endfunction

  // Register file
  logic single_chip_q;
  logic [31:0] vbr_q;
  logic [143:0] prio_q;
  logic [31:0] prdata_q;

  // Pin synchronisers and filtered levels: bit 8 is NMI, 7..0 external lines
  logic [8:0] s1_q, s2_q, s3_q, flt_q;
  logic [8:0] flt_d;
  logic nmi_prev_q;

  // Exception state
  aei_state_t st_q, st_d;
  logic cpu_err_q, dma_err_q, nmi_pend_q;
  logic [7:0] vec_q;
  logic [4:0] lvl_q;
  logic [31:0] sp_q, pc_q, sr_new_q, target_q;
  logic [31:0] mem_addr_q, mem_wdata_q;
  logic mem_we_q, jump_q, int_ack_q;

  // APB decode
  wire logic [2:0] pidx = prio_index(PADDR);
  wire logic hit_ctrl = (PADDR == AEI_OFF_CTRL);
  wire logic hit_vbr = (PADDR == AEI_OFF_VBR);
  wire logic hit_stat = (PADDR == AEI_OFF_STAT);
  wire logic hit_prio = (PADDR >= AEI_OFF_PRIO0) && (PADDR[1:0] == 2'h0) && (32'(pidx) < AEI_NPRIO_REGS)
    && (PADDR < AEI_OFF_PRIO0 + 12'h020);
  wire logic mapped = hit_ctrl | hit_vbr | hit_stat | hit_prio;
  wire logic wr_en = PSEL & PENABLE & PWRITE & mapped;
  wire logic rd_setup = PSEL & ~PENABLE & ~PWRITE;
  wire logic [159:0] prio_ext = {16'h0000, prio_q};

  logic [31:0] stat_word;
  logic [159:0] prio_new;
  logic [31:0] rd_mux;

  always_comb begin
    stat_word = 32'h00000000;
    stat_word[AEI_ST_CPUERR] = cpu_err_q;
    stat_word[AEI_ST_DMAERR] = dma_err_q;
    stat_word[AEI_ST_NMI] = nmi_pend_q;
    stat_word[AEI_ST_BUSY] = EXC_BUSY;
    stat_word[AEI_ST_VEC_LSB +: 8] = vec_q;
    stat_word[AEI_ST_LVL_LSB +: 5] = lvl_q;
  end

  // Fields are four bits wide, so level 16 cannot be written
  always_comb begin
    prio_new = prio_ext;
    if (wr_en && hit_prio) begin
      prio_new[32'(pidx) * 32 +: 32] = PWDATA; // RULE16
    end
  end

  assign rd_mux = hit_ctrl ? {31'h0, single_chip_q} :
                  hit_vbr ? vbr_q :
                  hit_stat ? stat_word :
                  hit_prio ? prio_ext[32'(pidx) * 32 +: 32] : 32'h00000000;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      single_chip_q <= AEI_CTRL_RST;
      vbr_q <= AEI_VBR_RST;
      prio_q <= AEI_PRIO_RST;
      prdata_q <= 32'h00000000;
    end else begin
      if (wr_en && hit_ctrl) begin
        single_chip_q <= PWDATA[AEI_CTRL_SC];
      end
      if (wr_en && hit_vbr) begin
        vbr_q <= PWDATA;
      end
      prio_q <= prio_new[143:0];
      if (rd_setup) begin
        prdata_q <= rd_mux;
      end
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  // Address checks
  wire logic a_odd = ACC_ADDR[0];
  wire logic ext_sc = ACC_EXTERNAL & single_chip_q;
  wire logic fetch_err = ACC_FETCH & (a_odd // RULE1
                         | ACC_PERIPH // RULE2
                         | ext_sc); // RULE3
  wire logic is_word = (ACC_SIZE == AEI_SZ_WORD);
  wire logic is_long = (ACC_SIZE == AEI_SZ_LONG);
  wire logic data_err = ~ACC_FETCH & ((is_word & a_odd) // RULE4
                        | (is_long & (ACC_ADDR[1:0] != 2'h0)) // RULE5
                        | (ACC_PERIPH & ACC_PERIPH8 & is_long) // RULE6
                        | ext_sc); // RULE7
  // Bus controller ends the offending cycle on this strobe
  assign ADDR_ERR = ACC_VALID & (fetch_err | data_err); // RULE8
  wire logic cpu_err_set = ADDR_ERR & (ACC_MASTER == AEI_MST_CPU);
  wire logic dma_err_set = ADDR_ERR & (ACC_MASTER != AEI_MST_CPU);

  // Pins: a change counts once the second and third stages agree
  wire logic [8:0] pin_raw = {NMI_PIN, ~IRQ_N};
  assign flt_d = (s2_q & s3_q) | (flt_q & (s2_q ^ s3_q));
  wire logic nmi_rise = flt_q[8] & ~nmi_prev_q;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s1_q <= 9'h000;
      s2_q <= 9'h000;
      s3_q <= 9'h000;
      flt_q <= 9'h000;
      nmi_prev_q <= 1'b0;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      flt_q <= flt_d;
      nmi_prev_q <= flt_q[8];
    end
  end

  // Source i has vector IRQ0 + i: lines 0..7, engine 8..11, timer 12..35
  wire logic [AEI_NSRC-1:0] src_req = {TMR_REQ, DMA_REQ, flt_q[7:0]}; // RULE11

  logic best_hit;
  logic [4:0] best_lvl;
  logic [7:0] best_vec;

  // Lowest index wins a tie; user break wins a tie at level 15
  always_comb begin
    best_hit = 1'b0;
    best_lvl = 5'h00;
    best_vec = 8'h00;
    for (int i = AEI_NSRC - 1; i >= 0; i--) begin
      if (src_req[i] && (!best_hit || src_level(prio_q, i) >= best_lvl)) begin // RULE17
        best_hit = 1'b1;
        best_lvl = src_level(prio_q, i); // RULE13
        best_vec = AEI_VEC_IRQ0 + 8'(i); // RULE12
      end
    end
    if (UBRK_REQ && (!best_hit || AEI_LVL_UBRK >= best_lvl)) begin
      best_hit = 1'b1;
      best_lvl = AEI_LVL_UBRK; // RULE15
      best_vec = AEI_VEC_UBRK;
    end
    if (nmi_pend_q) begin
      best_hit = 1'b1;
      best_lvl = AEI_LVL_NMI; // RULE14
      best_vec = AEI_VEC_NMI;
    end
  end

  wire logic [3:0] cur_mask = STATUS_WORD[AEI_MASK_LSB +: 4];
  wire logic int_accept = nmi_pend_q // RULE14
                          | (best_hit & (best_lvl > {1'b0, cur_mask})); // RULE18
  wire logic err_any = cpu_err_q | dma_err_q;
  // Entry only at an instruction boundary and only from idle
  wire logic start = (st_q == ST_IDLE) & INSN_DONE & (err_any | int_accept); // RULE8 RULE24
  wire logic take_cpu = start & cpu_err_q;
  wire logic take_dma = start & ~cpu_err_q & dma_err_q;
  wire logic take_int = start & ~err_any;
  wire logic take_nmi = take_int & nmi_pend_q;
  wire logic [7:0] start_vec = cpu_err_q ? AEI_VEC_CPU_AERR : dma_err_q ? AEI_VEC_DMA_AERR : best_vec;
  wire logic [3:0] new_mask = nmi_pend_q ? AEI_NMI_MASK : best_lvl[3:0];
  wire logic [31:0] sr_masked = (STATUS_WORD & ~(32'h0000000F << AEI_MASK_LSB))
                                | ({28'h0, new_mask} << AEI_MASK_LSB);
  wire logic [31:0] vec_addr = vbr_q + {22'h0, vec_q, 2'h0}; // RULE22

  // Memory handshake completions, one per memory step of the entry (the jump step has none)
  wire logic ack_sr = (st_q == ST_PUSH_SR) & MEM_ACK;
  wire logic ack_pc = (st_q == ST_PUSH_PC) & MEM_ACK;
  wire logic ack_vec = (st_q == ST_VEC) & MEM_ACK;

  // Pending flags: a new event in the clearing cycle is kept
  wire logic cpu_err_d = cpu_err_set | (cpu_err_q & ~take_cpu);
  wire logic dma_err_d = dma_err_set | (dma_err_q & ~take_dma);
  wire logic nmi_pend_d = nmi_rise | (nmi_pend_q & ~take_nmi);

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (start) begin
          st_d = ST_PUSH_SR;
        end
      end
      ST_PUSH_SR: begin
        if (MEM_ACK) begin
          st_d = ST_PUSH_PC;
        end
      end
      ST_PUSH_PC: begin
        if (MEM_ACK) begin
          st_d = ST_VEC;
        end
      end
      ST_VEC: begin
        if (MEM_ACK) begin
          st_d = ST_JUMP;
        end
      end
      ST_JUMP: begin
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= ST_IDLE;
      cpu_err_q <= 1'b0;
      dma_err_q <= 1'b0;
      nmi_pend_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cpu_err_q <= cpu_err_d;
      dma_err_q <= dma_err_d;
      nmi_pend_q <= nmi_pend_d;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      vec_q <= 8'h00;
      lvl_q <= 5'h00;
      pc_q <= 32'h00000000;
      sr_new_q <= 32'h00000000;
    end else if (start) begin
      vec_q <= start_vec;
      lvl_q <= take_int ? best_lvl : 5'h00;
      pc_q <= NEXT_PC; // RULE9 RULE23
      sr_new_q <= take_int ? sr_masked : STATUS_WORD; // RULE20
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sp_q <= 32'h00000000;
      mem_addr_q <= 32'h00000000;
      mem_wdata_q <= 32'h00000000;
      mem_we_q <= 1'b0;
    end else begin
      if (start) begin
        sp_q <= SP_IN - AEI_STACK_STEP;
        mem_addr_q <= SP_IN - AEI_STACK_STEP;
        mem_wdata_q <= STATUS_WORD; // RULE9 RULE19
        mem_we_q <= 1'b1;
      end
      if (ack_sr) begin
        sp_q <= sp_q - AEI_STACK_STEP;
        mem_addr_q <= sp_q - AEI_STACK_STEP;
        mem_wdata_q <= pc_q; // RULE9 RULE19
      end
      if (ack_pc) begin
        mem_addr_q <= vec_addr; // RULE10 RULE21
        mem_we_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      target_q <= 32'h00000000;
      jump_q <= 1'b0;
      int_ack_q <= 1'b0;
    end else begin
      jump_q <= ack_vec;
      int_ack_q <= take_int;
      if (ack_vec) begin
        target_q <= MEM_RDATA; // RULE10 RULE21
      end
    end
  end

  assign MEM_REQ = (st_q == ST_PUSH_SR) | (st_q == ST_PUSH_PC) | (st_q == ST_VEC);
  assign MEM_WE = mem_we_q;
  assign MEM_ADDR = mem_addr_q;
  assign MEM_WDATA = mem_wdata_q;
  assign EXC_BUSY = (st_q != ST_IDLE); // RULE24
  // Plain jump: the pipeline discards anything behind it, no delay slot
  assign EXC_JUMP = jump_q; // RULE10
  assign EXC_TARGET = target_q;
  assign EXC_SR = sr_new_q;
  assign EXC_SP = sp_q;
  assign INT_ACK = int_ack_q;
  assign INT_ACK_VEC = vec_q;

endmodule

// ### rtl/aei_pkg.sv
package aei_pkg;

  // Register byte offsets on the APB slave
  localparam logic [11:0] AEI_OFF_CTRL = 12'h000;
  localparam logic [11:0] AEI_OFF_VBR = 12'h004;
  localparam logic [11:0] AEI_OFF_STAT = 12'h008;
  localparam logic [11:0] AEI_OFF_PRIO0 = 12'h010;
  localparam int AEI_NPRIO_REGS = 5;

  // Field positions
  localparam int AEI_CTRL_SC = 0;
  localparam int AEI_ST_CPUERR = 0;
  localparam int AEI_ST_DMAERR = 1;
  localparam int AEI_ST_NMI = 2;
  localparam int AEI_ST_BUSY = 3;
  localparam int AEI_ST_VEC_LSB = 8;
  localparam int AEI_ST_LVL_LSB = 16;
  localparam int AEI_MASK_LSB = 4;

  // Reset values
  localparam logic AEI_CTRL_RST = 1'b0;
  localparam logic [31:0] AEI_VBR_RST = 32'h00000000;
  localparam logic [143:0] AEI_PRIO_RST = 144'h0;

  // Source counts: external lines, transfer engine, multifunction timer
  localparam int AEI_NIRQ = 8;
  localparam int AEI_NDMA = 4;
  localparam int AEI_NTMR = 24;
  localparam int AEI_NSRC = 36;

  // Vector numbers
  localparam logic [7:0] AEI_VEC_CPU_AERR = 8'h09;
  localparam logic [7:0] AEI_VEC_DMA_AERR = 8'h0A;
  localparam logic [7:0] AEI_VEC_NMI = 8'h0B;
  localparam logic [7:0] AEI_VEC_UBRK = 8'h0C;
  localparam logic [7:0] AEI_VEC_IRQ0 = 8'h40;

  // Priority levels
  localparam logic [4:0] AEI_LVL_NMI = 5'h10;
  localparam logic [4:0] AEI_LVL_UBRK = 5'h0F;
  localparam logic [3:0] AEI_NMI_MASK = 4'hF;

  // Access size and master codes
  localparam logic [1:0] AEI_SZ_BYTE = 2'h0;
  localparam logic [1:0] AEI_SZ_WORD = 2'h1;
  localparam logic [1:0] AEI_SZ_LONG = 2'h2;
  localparam logic [1:0] AEI_MST_CPU = 2'h0;

  localparam logic [31:0] AEI_STACK_STEP = 32'h00000004;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PUSH_SR = 3'h1,
    ST_PUSH_PC = 3'h2,
    ST_VEC = 3'h3,
    ST_JUMP = 3'h4
  } aei_state_t;

endpackage

// ### bench/aei_chk.sv
`timescale 1ns/1ps
module aei_chk
  import aei_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic ACC_VALID,
  input wire logic ACC_FETCH,
  input wire logic [1:0] ACC_SIZE,
  input wire logic [31:0] ACC_ADDR,
  input wire logic ACC_PERIPH,
  input wire logic ACC_PERIPH8,
  input wire logic ACC_EXTERNAL,
  input wire logic ADDR_ERR,
  input wire logic [31:0] STATUS_WORD,
  input wire logic [31:0] SP_IN,
  input wire logic EXC_BUSY,
  input wire logic EXC_JUMP,
  input wire logic INT_ACK,
  input wire logic MEM_REQ,
  input wire logic MEM_WE,
  input wire logic [31:0] MEM_ADDR,
  input wire logic [31:0] MEM_WDATA
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  wire logic fch = ACC_VALID && ACC_FETCH;
  wire logic dat = ACC_VALID && !ACC_FETCH;
  wire logic lng = dat && ACC_SIZE == AEI_SZ_LONG;
  a_fetch_odd: assert property (fch && ACC_ADDR[0] |-> ADDR_ERR) else $error("odd fetch passed");
  a_fetch_periph: assert property (fch && ACC_PERIPH |-> ADDR_ERR) else $error("fetch passed");
  a_fetch_ok: assert property (fch && !ACC_PERIPH && !ACC_EXTERNAL && !ACC_ADDR[0] |-> !ADDR_ERR)
    else $error("legal fetch flagged");
  a_word_odd: assert property (dat && ACC_SIZE == AEI_SZ_WORD && ACC_ADDR[0] |-> ADDR_ERR)
    else $error("odd word passed");
  a_long_align: assert property (lng && ACC_ADDR[1:0] != 2'h0 |-> ADDR_ERR) else $error("long passed");
  a_narrow_long: assert property (lng && ACC_PERIPH8 |-> ADDR_ERR) else $error("narrow long passed");
  a_data_ok: assert property (dat && !ACC_EXTERNAL && !ACC_PERIPH8 && ACC_ADDR[1:0] == 2'h0 |-> !ADDR_ERR)
    else $error("legal data flagged");
  a_stack_first: assert property ($rose(MEM_REQ) |-> MEM_WE && MEM_ADDR == SP_IN - 32'h4 &&
    MEM_WDATA == STATUS_WORD) else $error("first push wrong");
  a_jump_pulse: assert property (EXC_JUMP |=> !EXC_JUMP) else $error("jump too long");
  a_ack_once: assert property (INT_ACK |=> !INT_ACK [*3]) else $error("second accept");
  a_busy_end: assert property ($fell(EXC_BUSY) |-> $past(EXC_JUMP)) else $error("entry cut");
  cover property (ADDR_ERR);
  cover property (INT_ACK);
  cover property (EXC_JUMP);
endmodule
bind aei_top aei_chk u_chk (.CORE_CLK, .RST_N, .ACC_VALID, .ACC_FETCH, .ACC_SIZE, .ACC_ADDR, .ACC_PERIPH,
  .ACC_PERIPH8, .ACC_EXTERNAL, .ADDR_ERR, .STATUS_WORD, .SP_IN, .EXC_BUSY, .EXC_JUMP, .INT_ACK, .MEM_REQ,
  .MEM_WE, .MEM_ADDR, .MEM_WDATA);

// ### bench/aei_mem.sv
`timescale 1ns/1ps
module aei_mem (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic req,
  input wire logic [31:0] addr,
  output logic ack,
  output logic [31:0] rdata
);
  logic [1:0] wait_q;
  logic [1:0] cnt_q;
  assign ack = req && wait_q == 2'h0;
  // Outside an answer the data lines wander
  assign rdata = ack ? addr ^ 32'h5A5A_0000 : 32'hBAD0_0000 | {30'h0, cnt_q};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 2'h0;
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      if (req) begin
        wait_q <= ack ? (slow ? cnt_q : 2'h0) : wait_q - 2'h1;
      end
    end
  end
endmodule

// ### bench/tb.sv
`timescale 1ns/1ps
module tb;
  import aei_pkg::*;
  logic CORE_CLK, RST_N, PSEL, PENABLE, PWRITE, ACC_VALID, ACC_FETCH, ACC_PERIPH, ACC_PERIPH8, ACC_EXTERNAL;
  logic NMI_PIN, UBRK_REQ, INSN_DONE, MEM_ACK, slow, err;
  logic PREADY, PSLVERR, ADDR_ERR, EXC_BUSY, EXC_JUMP, INT_ACK, MEM_REQ, MEM_WE;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, ACC_ADDR, STATUS_WORD, NEXT_PC, SP_IN, EXC_TARGET, EXC_SR, EXC_SP;
  logic [31:0] MEM_ADDR, MEM_WDATA, MEM_RDATA, rd, vector_base_register, r, sr0;
  logic [1:0] ACC_SIZE, ACC_MASTER;
  logic [7:0] IRQ_N, INT_ACK_VEC;
  logic [3:0] DMA_REQ;
  logic [23:0] TMR_REQ;
  logic [63:0] q[$];
  logic [7:0] aq[$];
  int n_fail = 0;
  int n_tests = 0;
  // fetch, size, master, low address, periph, narrow, external, error
  logic [11:0] tbl [13] = '{12'hA20, 12'hA11, 12'hA09, 12'h220, 12'h2B1, 12'h440, 12'h421, 12'h01C,
    12'h408, 12'h40D, 12'h402, 12'hA03, 12'h113};
  aei_top u_dut (.CORE_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .ACC_VALID, .ACC_FETCH, .ACC_SIZE, .ACC_MASTER, .ACC_ADDR, .ACC_PERIPH, .ACC_PERIPH8, .ACC_EXTERNAL,
    .ADDR_ERR, .NMI_PIN, .IRQ_N, .UBRK_REQ, .DMA_REQ, .TMR_REQ, .INSN_DONE, .STATUS_WORD, .NEXT_PC, .SP_IN,
    .EXC_BUSY, .EXC_JUMP, .EXC_TARGET, .EXC_SR, .EXC_SP, .INT_ACK, .INT_ACK_VEC, .MEM_REQ, .MEM_WE,
    .MEM_ADDR, .MEM_WDATA, .MEM_ACK, .MEM_RDATA);
  aei_mem u_mem (.clk(CORE_CLK), .rst_n(RST_N), .slow(slow), .req(MEM_REQ), .addr(MEM_ADDR), .ack(MEM_ACK),
    .rdata(MEM_RDATA));
  initial CORE_CLK = 1'b0;
  always #12.5 CORE_CLK = ~CORE_CLK;
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int i;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    i = 0;
    do begin
      @(posedge CORE_CLK);
      i++;
    end while (PREADY !== 1'b1 && i < 20);
    if (PREADY !== 1'b1) begin
      n_fail++;
      final_report();
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CORE_CLK);
  endtask
  task wait_q;
    for (int i = 0; i < 300 && q.size() > 0; i++) @(posedge CORE_CLK);
    if (q.size() > 0 || aq.size() > 0) begin
      n_fail++;
      final_report();
    end
    @(posedge CORE_CLK);
  endtask
  function automatic logic [31:0] srm(input logic [3:0] m);
    return {STATUS_WORD[31:8], m, STATUS_WORD[3:0]};
  endfunction
  // Notes the four steps of one entry: two pushes, vector read, jump
  task ex(input logic [7:0] v, input logic [31:0] sr);
    q.push_back({SP_IN - 32'h4, STATUS_WORD});
    q.push_back({SP_IN - 32'h8, NEXT_PC});
    q.push_back({vector_base_register + {22'h0, v, 2'h0}, 32'h0});
    q.push_back({(vector_base_register + {22'h0, v, 2'h0}) ^ 32'h5A5A_0000, sr});
    if (v > AEI_VEC_DMA_AERR) aq.push_back(v);
  endtask
  always @(posedge CORE_CLK) begin
    if (!RST_N) STATUS_WORD <= sr0;
    if (RST_N && INT_ACK) begin
      if (aq.size() == 0) begin
        n_fail++;
        $display("unexpected accept vector exp none got %h", INT_ACK_VEC);
      end else begin
        chk("accept vector", {24'h0, aq[0]}, {24'h0, INT_ACK_VEC});
        void'(aq.pop_front());
      end
    end
    if (RST_N && ((MEM_REQ && MEM_ACK) || EXC_JUMP)) begin
      if (q.size() == 0) begin
        n_fail++;
        $display("unexpected entry step exp none got %h", MEM_ADDR);
      end else if (EXC_JUMP) begin
        chk("target", q[0][63:32], EXC_TARGET);
        chk("status", q[0][31:0], EXC_SR);
        chk("stack pointer", SP_IN - 32'h8, EXC_SP);
        void'(q.pop_front());
        STATUS_WORD <= EXC_SR;
      end else begin
        chk("stack address", q[0][63:32], MEM_ADDR);
        chk("stack data", q[0][31:0], MEM_WE ? MEM_WDATA : 32'h0);
        void'(q.pop_front());
      end
    end
  end
  initial begin
    void'($urandom(32'h878A));
    RST_N = 1'b0;
    {PSEL, PENABLE, PWRITE, ACC_VALID, ACC_FETCH, ACC_PERIPH, ACC_PERIPH8, ACC_EXTERNAL} = '0;
    {NMI_PIN, UBRK_REQ, INSN_DONE, slow, PADDR, PWDATA, ACC_ADDR, ACC_SIZE, ACC_MASTER} = '0;
    {DMA_REQ, TMR_REQ} = '0;
    IRQ_N = 8'hFF;
    SP_IN = 32'h0000_1000;
    sr0 = $urandom & 32'hFFFF_FF0F;
    NEXT_PC = $urandom & 32'hFFFF_FFFE;
    vector_base_register = $urandom & 32'hFFFF_FC00;
    repeat (6) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    @(posedge CORE_CLK);
    apb(1'b0, AEI_OFF_VBR, 32'h0);
    chk("vbr reset", 32'h0, rd);
    apb(1'b1, AEI_OFF_VBR, vector_base_register);
    apb(1'b0, AEI_OFF_VBR, 32'h0);
    chk("vbr", vector_base_register, rd);
    apb(1'b0, 12'h0FC, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    $display("test registers done");
    for (int i = 0; i < 13; i++) begin
      if (i == 11) apb(1'b1, AEI_OFF_CTRL, 32'h1);
      r = $urandom & 32'h0FFF_FFF0;
      ACC_VALID <= 1'b1;
      {ACC_FETCH, ACC_SIZE, ACC_MASTER} <= tbl[i][11:7];
      ACC_ADDR <= r | {29'h0, tbl[i][6:4]};
      {ACC_PERIPH, ACC_PERIPH8, ACC_EXTERNAL} <= tbl[i][3:1];
      @(posedge CORE_CLK);
      chk("addr_err", {31'h0, tbl[i][0]}, {31'h0, ADDR_ERR});
    end
    ACC_VALID <= 1'b0;
    apb(1'b1, AEI_OFF_CTRL, 32'h0);
    chk("busy", 32'h0, {31'h0, EXC_BUSY});
    ex(AEI_VEC_CPU_AERR, STATUS_WORD);
    ex(AEI_VEC_DMA_AERR, STATUS_WORD);
    INSN_DONE <= 1'b1;
    wait_q();
    $display("test address errors done");
    apb(1'b1, AEI_OFF_PRIO0, 32'h1000_0000);
    ex(AEI_VEC_IRQ0 + 8'h07, srm(4'h1));
    IRQ_N <= 8'h7F;
    wait_q();
    IRQ_N <= 8'hFF;
    apb(1'b1, AEI_OFF_PRIO0 + 12'h4, 32'h1);
    DMA_REQ <= 4'h1;
    repeat (10) @(posedge CORE_CLK);
    chk("busy", 32'h0, {31'h0, EXC_BUSY});
    ex(AEI_VEC_IRQ0 + 8'h08, srm(4'h2));
    apb(1'b1, AEI_OFF_PRIO0 + 12'h4, 32'h2);
    wait_q();
    DMA_REQ <= 4'h0;
    slow <= 1'b1;
    apb(1'b1, AEI_OFF_PRIO0 + 12'h4, 32'h0009_0082);
    ex(AEI_VEC_IRQ0 + 8'h0C, srm(4'h9));
    DMA_REQ <= 4'h2;
    TMR_REQ <= 24'h1;
    wait_q();
    TMR_REQ <= 24'h0;
    ex(AEI_VEC_UBRK, srm(4'hF));
    UBRK_REQ <= 1'b1;
    wait_q();
    UBRK_REQ <= 1'b0;
    DMA_REQ <= 4'h0;
    ex(AEI_VEC_NMI, srm(4'hF));
    NMI_PIN <= 1'b1;
    wait_q();
    NMI_PIN <= 1'b0;
    $display("test interrupts done");
    final_report();
  end
endmodule
